/* File: dps_chk.sv */
`timescale 1ns/1ps
module dps_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic runCmdPin,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic driveRun,
  input wire logic runTimeReached,
  input wire logic overloadFault
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  b_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  ar_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  b_release_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not reopened");
  r_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  // Synchroniser plus state register need the command low for a few edges
  run_drop_a: assert property (!runCmdPin [*5] |-> !driveRun)
    else $error("drive runs without command");
  fault_clear_a: assert property ($fell(overloadFault) |-> bvalid)
    else $error("fault cleared without write");
  runtime_clear_a: assert property ($fell(driveRun) |-> ##[0:2] !runTimeReached)
    else $error("run time flag outlived run");
endmodule

bind dps_supervisor dps_chk i_chk (
  .mclk(mclk), .rst_n(rst_n), .runCmdPin(runCmdPin), .arvalid(arvalid),
  .arready(arready), .awready(awready), .wready(wready), .bvalid(bvalid),
  .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .driveRun(driveRun), .runTimeReached(runTimeReached), .overloadFault(overloadFault)
);

/* File: dps_delay_timer.sv */
`timescale 1ns/1ps
module dps_delay_timer #(
  parameter int PRESCALE = 100,
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic [W-1:0] target,
  output logic done
);

  localparam int SW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [SW-1:0] SUB_LAST = SW'(PRESCALE - 1);

  generate
    if (PRESCALE < 1 || W < 1) begin : g_bad
      $error("dps_delay_timer: PRESCALE and W must be at least 1");
    end
  endgenerate

  logic [SW-1:0] sub;
  logic [W-1:0] units;

  // Restarts from zero whenever the condition drops
  // tick driven count
  always_ff @(posedge mclk) begin
    if (!rst_n || !enable) begin
      sub <= '0;
      units <= '0;
      done <= 1'b0;
    end else if (tick) begin
      if (units >= target) begin
        done <= 1'b1;
      end else if (sub == SUB_LAST) begin
        sub <= '0;
        units <= units + 1'b1;
      end else begin
        sub <= sub + 1'b1;
      end
    end
  end

endmodule

/* File: dps_pkg.sv */
package dps_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_SEC = 1_000_000 / TICK_US;
  localparam int TICKS_PER_DSEC = TICKS_PER_SEC / 10;
  localparam int TICKS_PER_DMIN = TICKS_PER_SEC * 6;

  // ----------------------------------------
  // Thresholds and scales
  // ----------------------------------------
  localparam logic [7:0] TEMP_MAX_C = 8'h4B;
  localparam logic [7:0] FAN_TEMP_C = 8'h28;
  localparam int PCT_FULL = 100;
  localparam int PERMIL_PER_PCT = 10;
  localparam int GAIN_UNITY = 100;
  localparam int POWER_UNITY = 1000;
  // Curve t = K / (I - knee) through 220%/60 s and 150%/3600 s
  localparam int OL_KNEE_PERMIL = 1488;
  localparam int OL_AREA_PCT_S = 4272;
  localparam int OL_LIMIT_UNITY = OL_AREA_PCT_S * PERMIL_PER_PCT * TICKS_PER_SEC / GAIN_UNITY;
  localparam logic [15:0] VBASE_220 = 16'h0122;
  localparam logic [15:0] VBASE_380 = 16'h0212;
  localparam logic [15:0] VBASE_480 = 16'h026C;
  localparam logic [15:0] VBASE_690 = 16'h0370;

  // ----------------------------------------
  // Register map, byte address = 4 * index
  // ----------------------------------------
  localparam int CFG_COUNT = 14;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TEMP_THR = 4'h1;
  localparam logic [3:0] REG_WAKE_FREQ = 4'h2;
  localparam logic [3:0] REG_WAKE_DELAY = 4'h3;
  localparam logic [3:0] REG_DORM_FREQ = 4'h4;
  localparam logic [3:0] REG_DORM_DELAY = 4'h5;
  localparam logic [3:0] REG_RUN_TARGET = 4'h6;
  localparam logic [3:0] REG_POWER_COEFF = 4'h7;
  localparam logic [3:0] REG_OL_GAIN = 4'h8;
  localparam logic [3:0] REG_OL_WARN = 4'h9;
  localparam logic [3:0] REG_OV_GAIN = 4'hA;
  localparam logic [3:0] REG_OV_THR = 4'hB;
  localparam logic [3:0] REG_OC_GAIN = 4'hC;
  localparam logic [3:0] REG_OC_THR = 4'hD;
  localparam logic [3:0] REG_STATUS = 4'hE;
  localparam logic [3:0] REG_POWER_MON = 4'hF;
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_MSB = 5;

  localparam int CTRL_FAN_BIT = 0;
  localparam int CTRL_OL_BIT = 1;
  localparam int CTRL_CLASS_LSB = 2;

  localparam logic [15:0] CFG_RESET [CFG_COUNT] = '{
    16'h0002, 16'h004B, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h03E8, 16'h0064, 16'h0050, 16'h0000, 16'h0082, 16'h0014, 16'h0096
  };

  localparam int ST_TEMP = 0;
  localparam int ST_FAN = 1;
  localparam int ST_RUNTIME = 2;
  localparam int ST_OLWARN = 3;
  localparam int ST_OLFAULT = 4;
  localparam int ST_OVSTALL = 5;
  localparam int ST_OCSTALL = 6;
  localparam int ST_DORMANT = 7;
  localparam int ST_RUN = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {CLASS_220, CLASS_380, CLASS_480, CLASS_690} dps_class_type;
  typedef enum {RUN_IDLE, RUN_ACTIVE, RUN_DORMANT} dps_run_type;

  typedef struct packed {
    logic [7:0] temp;
    logic [15:0] busVolt;
    logic [15:0] current;
    logic [15:0] setFreq;
    logic [15:0] rawPower;
  } dps_meas_type;

  typedef struct packed {
    logic accel;
    logic decel;
  } dps_ramp_type;

endpackage

/* File: dps_plant.sv */
`timescale 1ns/1ps
module dps_plant (
  input wire logic mclk,
  input wire logic driveRun,
  input wire logic rampHold,
  input wire dps_pkg::dps_meas_type lvl,
  output dps_pkg::dps_meas_type meas,
  output dps_pkg::dps_ramp_type ramp
);
  // ----------------------------------------
  // Power stage and ramp generator
  // ----------------------------------------
  // no PID source
  // Set frequency comes straight from the bench, so no stop-state PID option applies
  logic [15:0] runFreq = 16'h0000;
  wire logic up = driveRun && runFreq < lvl.setFreq;
  wire logic down = driveRun && runFreq > lvl.setFreq;
  assign meas = lvl;
  assign ramp = '{accel: up, decel: down};
  always @(posedge mclk) begin
    if (!driveRun)
      runFreq <= 16'h0000;
    else if (!rampHold)
      runFreq <= runFreq + {15'h0000, up} - {15'h0000, down};
  end
endmodule

/* File: dps_supervisor.sv */
`timescale 1ns/1ps
module dps_supervisor #(
  parameter int TICK_CYCLES = dps_pkg::TICK_CYCLES,
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dps_pkg::dps_meas_type meas,
  input wire dps_pkg::dps_ramp_type ramp,
  input wire logic runCmdPin,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic driveRun,
  output logic rampHold,
  output logic fanOn,
  output logic tempReached,
  output logic runTimeReached,
  output logic overloadWarn,
  output logic overloadFault,
  output logic [15:0] powerReport
);

  generate
    if (TICK_CYCLES < 1 || ADDR_W < 7) begin : g_bad
      $error("dps_supervisor: TICK_CYCLES >= 1 and ADDR_W >= 7 required");
    end
  endgenerate

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    return (a >> (dps_pkg::REG_IDX_MSB + 1)) == '0;
  endfunction

  function automatic logic [3:0] addrIndex(input logic [ADDR_W-1:0] a);
    return a[dps_pkg::REG_IDX_MSB:dps_pkg::REG_IDX_LSB];
  endfunction

  // ----------------------------------------
  // Control tick
  // ----------------------------------------
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  logic [TW-1:0] tickCount;
  logic tick;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tickCount <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tickCount == TICK_LAST);
      tickCount <= (tickCount == TICK_LAST) ? '0 : tickCount + 1'b1;
    end
  end

  // Run command arrives from a terminal
  logic runSync1;
  logic runSync2;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      runSync1 <= 1'b0;
      runSync2 <= 1'b0;
    end else begin
      runSync1 <= runCmdPin;
      runSync2 <= runSync1;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [15:0] cfg [dps_pkg::CFG_COUNT];
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic [15:0] status;

  wire doWrite = !awready && !wready && !bvalid;
  wire [3:0] wrIdx = addrIndex(awAddrHeld);
  wire wrOk = addrMapped(awAddrHeld);
  wire clearFault = doWrite && wrOk && wrIdx == dps_pkg::REG_STATUS
                    && wStrbHeld[0] && wDataHeld[dps_pkg::ST_OLFAULT];
  wire [3:0] rdIdx = addrIndex(araddr);
  wire [15:0] rdWord = (rdIdx == dps_pkg::REG_STATUS) ? status :
                       (rdIdx == dps_pkg::REG_POWER_MON) ? powerReport :
                       cfg[rdIdx];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= dps_pkg::RESP_OKAY;
      awAddrHeld <= '0;
      wDataHeld <= '0;
      wStrbHeld <= '0;
    end else begin
      if (awvalid && awready) begin
        awAddrHeld <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrOk ? dps_pkg::RESP_OKAY : dps_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= dps_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= addrMapped(araddr) ? {16'h0000, rdWord} : 32'h00000000;
      rresp <= addrMapped(araddr) ? dps_pkg::RESP_OKAY : dps_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < dps_pkg::CFG_COUNT; gi++) begin : g_cfg
      wire hit = doWrite && wrOk && wrIdx == 4'(gi);
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cfg[gi] <= dps_pkg::CFG_RESET[gi];
        end else if (hit) begin
          if (wStrbHeld[0]) begin
            cfg[gi][7:0] <= wDataHeld[7:0];
          end
          if (wStrbHeld[1]) begin
            cfg[gi][15:8] <= wDataHeld[15:8];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  wire [15:0] ctrl = cfg[dps_pkg::REG_CTRL];
  wire fanAlways = ctrl[dps_pkg::CTRL_FAN_BIT];
  wire olEnable = ctrl[dps_pkg::CTRL_OL_BIT];
  wire [1:0] vClass = ctrl[dps_pkg::CTRL_CLASS_LSB +: 2];
  wire [7:0] tempThrRaw = cfg[dps_pkg::REG_TEMP_THR][7:0];
  wire [15:0] wakeFreq = cfg[dps_pkg::REG_WAKE_FREQ];
  wire [15:0] dormFreq = cfg[dps_pkg::REG_DORM_FREQ];

  // Out-of-range temperature thresholds are clamped at the top of the range where used; the register keeps the written value
  // threshold ceiling
  wire [7:0] tempThr = (tempThrRaw > dps_pkg::TEMP_MAX_C) ? dps_pkg::TEMP_MAX_C : tempThrRaw;

  wire [15:0] vBase = (vClass == dps_pkg::CLASS_220) ? dps_pkg::VBASE_220 :
                      (vClass == dps_pkg::CLASS_380) ? dps_pkg::VBASE_380 :
                      (vClass == dps_pkg::CLASS_480) ? dps_pkg::VBASE_480 :
                      dps_pkg::VBASE_690;
  wire [31:0] ovLimit = (32'(vBase) * 32'(cfg[dps_pkg::REG_OV_THR])) / 32'(dps_pkg::PCT_FULL);
  wire [31:0] ocLimit = 32'(cfg[dps_pkg::REG_OC_THR]) * 32'(dps_pkg::PERMIL_PER_PCT);

  // ----------------------------------------
  // Dormant and wakeup sequencing
  // ----------------------------------------
  dps_pkg::dps_run_type runState;
  dps_pkg::dps_run_type next_runState;
  logic dormDone;
  logic wakeDone;
  logic runDone;

  wire dormEnable = (wakeFreq != 16'h0000) || (dormFreq != 16'h0000);
  wire dormCond = runState == dps_pkg::RUN_ACTIVE && dormEnable && meas.setFreq <= dormFreq;
  wire wakeCond = runState == dps_pkg::RUN_DORMANT && runSync2 && meas.setFreq >= wakeFreq;

  dps_delay_timer #(
    .PRESCALE(dps_pkg::TICKS_PER_DSEC),
    .W(16)
  ) u_dormTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(dormCond),
    .target(cfg[dps_pkg::REG_DORM_DELAY]),
    .done(dormDone)
  );

  dps_delay_timer #(
    .PRESCALE(dps_pkg::TICKS_PER_DSEC),
    .W(16)
  ) u_wakeTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(wakeCond),
    .target(cfg[dps_pkg::REG_WAKE_DELAY]),
    .done(wakeDone)
  );

  always_comb begin
    next_runState = runState;
    case (runState)
      dps_pkg::RUN_IDLE: begin
        if (runSync2) begin
          next_runState = dps_pkg::RUN_ACTIVE;
        end
      end
      dps_pkg::RUN_ACTIVE: begin
        if (!runSync2) begin
          next_runState = dps_pkg::RUN_IDLE;
        end else if (dormDone) begin
          next_runState = dps_pkg::RUN_DORMANT;
        end
      end
      dps_pkg::RUN_DORMANT: begin
        if (!runSync2) begin
          next_runState = dps_pkg::RUN_IDLE;
        end else if (!dormEnable || wakeDone) begin
          next_runState = dps_pkg::RUN_ACTIVE;
        end
      end
      default: next_runState = dps_pkg::RUN_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      runState <= dps_pkg::RUN_IDLE;
      driveRun <= 1'b0;
    end else begin
      runState <= next_runState;
      driveRun <= next_runState == dps_pkg::RUN_ACTIVE;
    end
  end

  // ----------------------------------------
  // Running time of the present run
  // ----------------------------------------
  dps_delay_timer #(
    .PRESCALE(dps_pkg::TICKS_PER_DMIN),
    .W(16)
  ) u_runTimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .enable(driveRun),
    .target(cfg[dps_pkg::REG_RUN_TARGET]),
    .done(runDone)
  );

  // ----------------------------------------
  // Overload accumulation
  // ----------------------------------------
  logic [31:0] olAccum;
  wire [31:0] olGain = 32'(cfg[dps_pkg::REG_OL_GAIN]);
  wire [31:0] olKnee = (32'(dps_pkg::OL_KNEE_PERMIL) * olGain) / 32'(dps_pkg::GAIN_UNITY);
  wire [31:0] olLimit = 32'(dps_pkg::OL_LIMIT_UNITY) * olGain;
  wire [31:0] olWarnLimit = (olLimit / 32'(dps_pkg::PCT_FULL)) * 32'(cfg[dps_pkg::REG_OL_WARN]);
  wire [31:0] curNow = 32'(meas.current);
  wire overKnee = curNow > olKnee;
  wire [31:0] olUp = olAccum + (curNow - olKnee);
  wire [31:0] olDown = olKnee - curNow;
  wire [31:0] olNext = overKnee ? ((olUp > olLimit) ? olLimit : olUp) :
                       ((olAccum > olDown) ? olAccum - olDown : 32'h00000000);

  always_ff @(posedge mclk) begin
    if (!rst_n || !olEnable) begin
      olAccum <= 32'h00000000;
    end else if (tick) begin
      olAccum <= olNext;
    end
  end

  // ----------------------------------------
  // Stall holds
  // ----------------------------------------
  logic [7:0] ovHoldCount;
  logic [7:0] ocHoldCount;
  logic ovStall;
  logic ocStall;
  wire [7:0] ovGain = cfg[dps_pkg::REG_OV_GAIN][7:0];
  wire [7:0] ocGain = cfg[dps_pkg::REG_OC_GAIN][7:0];
  wire ovTrip = ramp.decel && ovGain != 8'h00 && 32'(meas.busVolt) > ovLimit;
  wire ocTrip = (ramp.accel || ramp.decel) && ocGain != 8'h00 && curNow > ocLimit;

  // Hold persists gain ticks after the trip clears, so larger gain suppresses longer
  // gain sets suppression
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovHoldCount <= 8'h00;
      ovStall <= 1'b0;
    end else if (tick) begin
      ovStall <= ovTrip || (ovHoldCount != 8'h00 && ovGain != 8'h00 && ramp.decel);
      ovHoldCount <= ovTrip ? ovGain : (ovHoldCount != 8'h00 ? ovHoldCount - 8'h01 : 8'h00);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ocHoldCount <= 8'h00;
      ocStall <= 1'b0;
    end else if (tick) begin
      ocStall <= ocTrip ||
                 (ocHoldCount != 8'h00 && ocGain != 8'h00 && (ramp.accel || ramp.decel));
      ocHoldCount <= ocTrip ? ocGain : (ocHoldCount != 8'h00 ? ocHoldCount - 8'h01 : 8'h00);
    end
  end

  // ----------------------------------------
  // Power correction
  // ----------------------------------------
  // linear scale
  wire [31:0] powerScaled = (32'(meas.rawPower) * 32'(cfg[dps_pkg::REG_POWER_COEFF]))
                            / 32'(dps_pkg::POWER_UNITY);
  // Saturates rather than wrapping at coefficients above unity
  wire [15:0] powerSat = (powerScaled > 32'h0000FFFF) ? 16'hFFFF : powerScaled[15:0];

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fanOn <= 1'b0;
      tempReached <= 1'b0;
      runTimeReached <= 1'b0;
      overloadWarn <= 1'b0;
      overloadFault <= 1'b0;
      rampHold <= 1'b0;
      powerReport <= 16'h0000;
    end else begin
      powerReport <= powerSat;
      rampHold <= ovStall || ocStall;
      if (fanAlways) begin
        fanOn <= 1'b1;
      end else if (driveRun) begin
        fanOn <= 1'b1;
      end else if (tick && meas.temp > dps_pkg::FAN_TEMP_C) begin
        fanOn <= 1'b1;
      end else if (tick && meas.temp < dps_pkg::FAN_TEMP_C) begin
        fanOn <= 1'b0;
      end
      if (tick) begin
        tempReached <= meas.temp >= tempThr;
        overloadWarn <= olEnable && olAccum > olWarnLimit;
      end
      runTimeReached <= runDone && cfg[dps_pkg::REG_RUN_TARGET] != 16'h0000;
      // Set wins over a clear in the same cycle
      // fault latch
      if (olEnable && olAccum >= olLimit && olLimit != 32'h00000000) begin
        overloadFault <= 1'b1;
      end else if (clearFault) begin
        overloadFault <= 1'b0;
      end
    end
  end

  always_comb begin
    status = 16'h0000;
    status[dps_pkg::ST_TEMP] = tempReached;
    status[dps_pkg::ST_FAN] = fanOn;
    status[dps_pkg::ST_RUNTIME] = runTimeReached;
    status[dps_pkg::ST_OLWARN] = overloadWarn;
    status[dps_pkg::ST_OLFAULT] = overloadFault;
    status[dps_pkg::ST_OVSTALL] = ovStall;
    status[dps_pkg::ST_OCSTALL] = ocStall;
    status[dps_pkg::ST_DORMANT] = runState == dps_pkg::RUN_DORMANT;
    status[dps_pkg::ST_RUN] = driveRun;
  end

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
    logic [1:0] r;
  } dps_row_type;
  localparam dps_row_type ROWS [3] = '{
    '{8'h04, 16'h0032, 16'h0032, 2'h0},
    '{8'h3C, 16'h1234, 16'h0000, 2'h0},
    '{8'h40, 16'h0001, 16'h0000, 2'h2}};
  logic mclk = 1'b0, rst_n = 1'b0, runCmdPin = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, d;
  logic [1:0] r;
  dps_pkg::dps_meas_type lvl = '0;
  wire dps_pkg::dps_meas_type meas;
  wire dps_pkg::dps_ramp_type ramp;
  wire logic awready, wready, bvalid, arready, rvalid, driveRun, rampHold, fanOn;
  wire logic tempReached, runTimeReached, overloadWarn, overloadFault;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] powerReport;
  int miscompares = 0, totalChecks = 0, n, t;

  always #2 mclk = ~mclk;

  dps_plant i_plant (.mclk(mclk), .driveRun(driveRun), .rampHold(rampHold), .lvl(lvl),
    .meas(meas), .ramp(ramp));
  dps_supervisor #(.TICK_CYCLES(10), .ADDR_W(8)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .meas(meas), .ramp(ramp), .runCmdPin(runCmdPin), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .driveRun(driveRun), .rampHold(rampHold), .fanOn(fanOn), .tempReached(tempReached),
    .runTimeReached(runTimeReached), .overloadWarn(overloadWarn),
    .overloadFault(overloadFault), .powerReport(powerReport));

  task automatic summarize;
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    totalChecks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Each channel released only at the edge its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] b);
    logic aw, w;
    @(posedge mclk);
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    b = bresp;
    tmo(n, 50);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    tmo(n, 50);
  endtask

  initial begin
    cyc(20);
    chk({driveRun, fanOn, tempReached, overloadFault, awready, arready}, 6'h03);
    rst_n <= 1'b1;
    for (int i = 0; i < dps_pkg::CFG_COUNT; i++) begin
      rd(8'(i * 4));
      chk(d, {16'h0000, dps_pkg::CFG_RESET[i]});
    end
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, r);
      chk(r, ROWS[i].r);
      rd(ROWS[i].a);
      chk({r, d}, {ROWS[i].r, 16'h0000, ROWS[i].e});
    end
    lvl.temp <= 8'h32;
    cyc(30);
    chk(tempReached, 1'b1);
    // Threshold above the ceiling must behave as the ceiling
    wr(8'h04, 16'h0064, r);
    lvl.temp <= 8'h4A;
    cyc(30);
    chk({tempReached, fanOn}, 2'h1);
    lvl.temp <= 8'h4B;
    cyc(30);
    chk(tempReached, 1'b1);
    lvl.temp <= 8'h27;
    cyc(30);
    chk(fanOn, 1'b0);
    wr(8'h00, 16'h0003, r);
    cyc(30);
    chk(fanOn, 1'b1);
    wr(8'h00, 16'h0002, r);
    runCmdPin <= 1'b1;
    lvl.rawPower <= 16'h03E8;
    wr(8'h1C, 16'h01F4, r);
    cyc(30);
    chk({driveRun, fanOn, powerReport}, {2'h3, 16'h01F4});
    wr(8'h14, 16'h0001, r);
    wr(8'h0C, 16'h0001, r);
    wr(8'h18, 16'h0001, r);
    lvl.setFreq <= 16'h012C;
    wr(8'h10, 16'h0064, r);
    wr(8'h08, 16'h00C8, r);
    lvl.setFreq <= 16'h0032;
    cyc(900);
    chk(driveRun, 1'b1);
    cyc(300);
    chk(driveRun, 1'b0);
    lvl.setFreq <= 16'h1388;
    cyc(900);
    chk(driveRun, 1'b0);
    cyc(300);
    chk(driveRun, 1'b1);
    cyc(58500);
    chk(runTimeReached, 1'b0);
    cyc(2000);
    chk(runTimeReached, 1'b1);
    wr(8'h10, 16'h0000, r);
    wr(8'h08, 16'h0000, r);
    wr(8'h00, 16'h0004, r);
    wr(8'h28, 16'h000A, r);
    lvl.setFreq <= 16'h0000;
    lvl.busVolt <= 16'h02B2;
    cyc(30);
    chk(rampHold, 1'b1);
    lvl.busVolt <= 16'h02B1;
    cyc(150);
    chk(rampHold, 1'b0);
    // Highest class: base 880 V, so 130 percent is 1144 V
    wr(8'h00, 16'h000C, r);
    lvl.busVolt <= 16'h0479;
    cyc(30);
    chk(rampHold, 1'b1);
    lvl.busVolt <= 16'h0478;
    cyc(150);
    chk(rampHold, 1'b0);
    wr(8'h28, 16'h0000, r);
    lvl.busVolt <= 16'h0300;
    cyc(30);
    chk(rampHold, 1'b0);
    lvl.current <= 16'h05DD;
    cyc(30);
    chk(rampHold, 1'b1);
    lvl.current <= 16'h0578;
    cyc(260);
    chk(rampHold, 1'b0);
    wr(8'h30, 16'h0000, r);
    lvl.current <= 16'hFFFF;
    cyc(8000);
    chk({rampHold, overloadWarn, overloadFault}, 3'h0);
    wr(8'h00, 16'h0006, r);
    for (t = 0; t < 20000 && overloadWarn !== 1'b1; t++) @(posedge mclk);
    tmo(t, 20000);
    chk(overloadFault, 1'b0);
    for (n = t; n < 20000 && overloadFault !== 1'b1; n++) @(posedge mclk);
    tmo(n, 20000);
    chk({n > 5000, n < 8000, t * 10 > n * 7, t * 10 < n * 9}, 4'hF);
    lvl.current <= 16'h0000;
    cyc(5000);
    chk(overloadFault, 1'b1);
    wr(8'h38, 16'h0010, r);
    cyc(5);
    chk(overloadFault, 1'b0);
    // 150 percent only creeps up, far from the limit within this window
    lvl.current <= 16'h05DC;
    cyc(2000);
    chk(overloadFault, 1'b0);
    runCmdPin <= 1'b0;
    cyc(10);
    chk({driveRun, runTimeReached}, 2'h0);
    summarize();
  end
endmodule
